// File: logic/edge_sync.v
// Two-stage synchroniser with rise and fall pulses
`timescale 1ns/100ps
module edge_sync
(
  // Clock and reset
  input  wire clk,
  input  wire rst_b,
  // Pin input
  input  wire pin,
  // Synchronised level and events
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg sync_q;
  reg last_q;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q; // see R19
  assign fall  = ~sync_q & last_q; // see R19
endmodule // edge_sync

// File: logic/vertical_event_sequencer.v
// Vertical event sequencer: frame-line counter and acquisition control
// Function
// R1 - Every operation takes its event from its own independent selector.
// R2 - Zero-release 0: counter passes through 0000h.
// R3 - Zero-release 1: halt at 0000h, resume on trigger rise.
// R4 - Zero-release 2: halt at 0000h while trigger low, trigger rise releases.
// R5 - Reset selector 0: reset at vertical window end.
// R6 - Reset selectors 1..5 choose trigger fall, table, frame rise combinations.
// R7 - Software reset and host abort always reset the counter.
// R8 - Stick-release 0: counter passes through 7FF0h.
// R9 - Stick-release 1: hold at 7FF0h until load or reset.
// R10 - Load forces 8000h; 0 none, 1 frame rise qualified by table.
// R11 - Load 2 any frame rise; load 3 trigger rise.
// R12 - Single capture takes one frame; continuous until freeze or abort.
// R13 - Acquire selector 0 host, 1 trigger-launched, 2 snap per trigger.
// R14 - Acquire selector 3: stream while trigger high, no commands.
// R15 - Freeze stops at once between frames, else at frame end; code: an armed single capture still takes its frame.
// R16 - Freeze selector: 0 host, 1 quota or host, 2 trigger fall.
// R17 - Abort ends capture immediately, even mid-frame.
// R18 - Abort selector: 0 host, 1 trigger fall or host.
// R19 - Trigger and frame-valid are synchronised into edge pulses.
`timescale 1ns/100ps
`include "vseq_defines.vh"
module vertical_event_sequencer
(
  // Clock and reset
  input  wire                 clk,
  input  wire                 rst_b,
  // External pins
  input  wire                 trigger_in,
  input  wire                 frame_valid_in,
  // Same-domain events
  input  wire                 line_tick,
  input  wire                 vertical_acquire_window_end,
  input  wire                 table_reset_event,
  input  wire                 vertical_load_enable,
  input  wire                 software_reset_event,
  input  wire                 frame_quota_reached,
  // Host command write
  input  wire                 host_cmd_write,
  input  wire [`CMD_W-1:0]    host_cmd,
  // Selectors
  input  wire [`SEL_W-1:0]    zero_release_select,
  input  wire [`SEL_W-1:0]    counter_reset_select,
  input  wire [`SEL_W-1:0]    stick_release_select,
  input  wire [`SEL_W-1:0]    counter_load_select,
  input  wire [`SEL_W-1:0]    acquire_initiator_select,
  input  wire [`SEL_W-1:0]    freeze_initiator_select,
  input  wire [`SEL_W-1:0]    abort_initiator_select,
  // Status
  output reg  [`CNT_W-1:0]    frame_line_counter,
  output reg                  acquire_active,
  output reg                  continuous_capture,
  output reg                  stream_active,
  output reg  [1:0]           acquire_state,
  output reg                  frame_done
);
  wire trigger_high_level;
  wire trigger_rise_event;
  wire trigger_fall_event;
  wire frame_valid_rise_event;
  wire frame_valid_fall_event;
  // Trigger low is the level-mode hold condition
  wire trigger_low_level = ~trigger_high_level;

  // Pins may change at any time, so events come only after two flops
  edge_sync u_trig_sync
  (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (trigger_in),
    .level (trigger_high_level),
    .rise  (trigger_rise_event),
    .fall  (trigger_fall_event)
  );

  edge_sync u_fv_sync
  (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (frame_valid_in),
    .level (),
    .rise  (frame_valid_rise_event),
    .fall  (frame_valid_fall_event)
  );

  // Host command decodes
  wire host_abort_write  = host_cmd_write & (host_cmd == `CMD_ABORT);
  wire host_freeze_write = host_cmd_write & (host_cmd == `CMD_FREEZE);

  // Counter operation decodes, each from its own selector
  reg sel_reset;
  reg sel_load;
  reg zero_hold;
  // Released flag remembers a trigger rise seen at zero
  reg released_q;
  reg released_d;

  always @*
  begin
    case (counter_reset_select) // see R1
      `RS_VAW:         sel_reset = vertical_acquire_window_end; // see R5
      `RS_TFALL_VAW:   sel_reset = trigger_fall_event | vertical_acquire_window_end; // see R6
      `RS_TABLE:       sel_reset = table_reset_event; // see R6
      `RS_FRAME:       sel_reset = frame_valid_rise_event; // see R6
      `RS_TFALL_TABLE: sel_reset = trigger_fall_event | table_reset_event; // see R6
      `RS_TFALL:       sel_reset = trigger_fall_event; // see R6
      default:         sel_reset = vertical_acquire_window_end;
    endcase
  end

  always @*
  begin
    case (counter_load_select) // see R1
      `LD_NONE:  sel_load = 1'b0; // see R10
      `LD_QUAL:  sel_load = frame_valid_rise_event & vertical_load_enable; // see R10
      `LD_FRAME: sel_load = frame_valid_rise_event; // see R11
      `LD_TRIG:  sel_load = trigger_rise_event; // see R11
      default:   sel_load = 1'b0;
    endcase
  end

  // A trigger rise seen while away from zero is not carried over
  always @*
  begin
    released_d = released_q;
    if (frame_line_counter != `CNT_ZERO)
      released_d = 1'b0;
    else if (trigger_rise_event)
      released_d = 1'b1;

    // Hold at zero as the selector asks
    case (zero_release_select)
      `ZR_NONE:  zero_hold = 1'b0; // see R2
      `ZR_EDGE:  zero_hold = ~released_d; // see R3
      `ZR_LEVEL: zero_hold = trigger_low_level & ~released_d; // see R4
      default:   zero_hold = 1'b0;
    endcase
  end

  // Software reset and host abort clear the counter whatever the selector says
  wire force_reset = software_reset_event | host_abort_write | sel_reset; // see R7
  wire stick_hold  = (stick_release_select == `ST_HOLD) & (frame_line_counter == `CNT_STICK); // see R9
  wire at_zero     = frame_line_counter == `CNT_ZERO;

  // Next counter value
  reg [`CNT_W-1:0] cnt_d;

  // Reset outranks load
  always @*
  begin
    cnt_d = frame_line_counter;
    if (force_reset)
      cnt_d = `CNT_ZERO; // see R7
    else if (sel_load)
      cnt_d = `CNT_LOAD; // see R10
    else if (line_tick && !(at_zero && zero_hold) && !stick_hold)
      cnt_d = frame_line_counter + 16'h0001; // see R8
  end

  // Counter and release flag
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frame_line_counter <= `CNT_ZERO;
      released_q         <= 1'b0;
    end
    else
    begin
      frame_line_counter <= cnt_d;
      released_q         <= released_d & ~force_reset;
    end
  end

  // Acquisition control
  reg [1:0] pend_q;
  reg [1:0] pend_d;
  reg [1:0] st_d;
  reg       cont_d;
  reg       done_d;

  // Event decodes
  reg       go;
  reg       freeze_ev;
  reg       abort_ev;

  always @*
  begin
    case (freeze_initiator_select) // see R16
      `FZ_HOST:  freeze_ev = host_freeze_write;
      `FZ_QUOTA: freeze_ev = frame_quota_reached | host_freeze_write;
      `FZ_TFALL: freeze_ev = trigger_fall_event;
      default:   freeze_ev = host_freeze_write;
    endcase
  end

  // Abort is kept apart from freeze so each follows only its own selector
  always @*
  begin
    case (abort_initiator_select) // see R18
      `AB_HOST:  abort_ev = host_abort_write;
      `AB_TFALL: abort_ev = trigger_fall_event | host_abort_write;
      default:   abort_ev = host_abort_write;
    endcase
  end

  // Pending command: host write, possibly launched later by the trigger
  wire host_capture = host_cmd_write & host_cmd[1];

  always @*
  begin
    pend_d = pend_q;
    go     = 1'b0;
    if (host_capture)
      pend_d = host_cmd;
    case (acquire_initiator_select) // see R13
      `AQ_HOST:
        go = pend_q[1];
      `AQ_TRIG:
        go = pend_q[1] & trigger_rise_event;
      `AQ_TSNAP:
        go = (pend_q == `CMD_CONT) & trigger_rise_event;
      default:
        go = 1'b0;
    endcase

    // Freeze and abort drop any waiting command
    if (abort_ev || freeze_ev)
      pend_d = 2'b00;
  end

  // State walk; abort always wins over freeze and frame end
  always @*
  begin
    st_d   = acquire_state;
    done_d = 1'b0;
    cont_d = continuous_capture;
    case (acquire_state)
      `AS_IDLE:
        if (acquire_initiator_select == `AQ_CONT)
          st_d = `AS_STREAM; // see R14
        else if (go && !abort_ev && !freeze_ev)
        begin
          st_d   = `AS_ARMED;
          cont_d = (pend_q == `CMD_CONT) && (acquire_initiator_select != `AQ_TSNAP); // see R12
        end
      `AS_ARMED:
        if (abort_ev)
          st_d = `AS_IDLE; // see R17
        else if (freeze_ev && continuous_capture)
          st_d = `AS_IDLE; // see R15
        else if (frame_valid_rise_event)
          st_d = `AS_FRAME;
      `AS_FRAME:
        if (abort_ev)
          st_d = `AS_IDLE; // see R17
        else
        begin
          // A freeze that meets the frame end must not swallow it
          if (freeze_ev && continuous_capture)
            cont_d = 1'b0; // see R15
          if (frame_valid_fall_event)
          begin
            done_d = 1'b1;
            st_d   = cont_d ? `AS_ARMED : `AS_IDLE; // see R12
          end
        end
      `AS_STREAM:
        if (acquire_initiator_select != `AQ_CONT)
          st_d = `AS_IDLE;
      default:
        st_d = `AS_IDLE;
    endcase
    if (st_d == `AS_IDLE)
      cont_d = 1'b0;
  end

  // Single captures consume the pending command; continuous keeps it for the trigger modes
  wire consume = (acquire_state == `AS_IDLE) && (st_d == `AS_ARMED) && (pend_q == `CMD_SINGLE);

  // Acquisition registers; every status output except frame_line_counter comes from here
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acquire_state      <= `AS_IDLE;
      pend_q             <= 2'b00;
      continuous_capture <= 1'b0;
      acquire_active     <= 1'b0;
      stream_active      <= 1'b0;
      frame_done         <= 1'b0;
    end
    else
    begin
      acquire_state      <= st_d;
      pend_q             <= consume ? 2'b00 : pend_d;
      continuous_capture <= cont_d;
      acquire_active     <= (st_d == `AS_FRAME);
      stream_active      <= (st_d == `AS_STREAM) & trigger_high_level; // see R14
      frame_done         <= done_d;
    end
  end
endmodule // vertical_event_sequencer

// File: logic/vseq_defines.vh
// Constants for the vertical event sequencer
`ifndef VSEQ_DEFINES_VH
`define VSEQ_DEFINES_VH
`define CNT_W          16
`define CNT_ZERO       16'h0000
`define CNT_STICK      16'h7FF0
`define CNT_LOAD       16'h8000
`define SEL_W          3
`define ZR_NONE        3'h0
`define ZR_EDGE        3'h1
`define ZR_LEVEL       3'h2
`define RS_VAW         3'h0
`define RS_TFALL_VAW   3'h1
`define RS_TABLE       3'h2
`define RS_FRAME       3'h3
`define RS_TFALL_TABLE 3'h4
`define RS_TFALL       3'h5
`define ST_NONE        3'h0
`define ST_HOLD        3'h1
`define LD_NONE        3'h0
`define LD_QUAL        3'h1
`define LD_FRAME       3'h2
`define LD_TRIG        3'h3
`define AQ_HOST        3'h0
`define AQ_TRIG        3'h1
`define AQ_TSNAP       3'h2
`define AQ_CONT        3'h3
`define FZ_HOST        3'h0
`define FZ_QUOTA       3'h1
`define FZ_TFALL       3'h2
`define AB_HOST        3'h0
`define AB_TFALL       3'h1
`define CMD_W          2
`define CMD_FREEZE     2'h0
`define CMD_ABORT      2'h1
`define CMD_SINGLE     2'h2
`define CMD_CONT       2'h3
`define AS_IDLE        2'h0
`define AS_ARMED       2'h1
`define AS_FRAME       2'h2
`define AS_STREAM      2'h3
`endif

// File: tb/sig_source.sv
// Trigger and frame-valid source model
`timescale 1ns/100ps
module sig_source
(
  // Clock
  input  wire clk,
  // Pins
  output reg  trigger_in,
  output reg  frame_valid_in
);
  initial {trigger_in, frame_valid_in} = 2'b00;
  // Levels change shortly after an edge, like a camera output register
  task trig(input v);
    begin
      @(posedge clk) #2 trigger_in = v;
    end
  endtask
  task frame(input v);
    begin
      @(posedge clk) #2 frame_valid_in = v;
    end
  endtask
endmodule // sig_source

// File: tb/testbench.sv
// Self-checking bench for the vertical event sequencer
`timescale 1ns/100ps
`include "vseq_defines.vh"
module testbench;
  reg clk = 0, rst_b = 0, line_tick = 0, vertical_acquire_window_end = 0, table_reset_event = 0;
  reg vertical_load_enable = 0, software_reset_event = 0, frame_quota_reached = 0, host_cmd_write = 0;
  reg [1:0] host_cmd = 0;
  reg [2:0] zero_release_select = 0, counter_reset_select = 2, stick_release_select = 1;
  reg [2:0] counter_load_select = 0, acquire_initiator_select = 0, freeze_initiator_select = 0;
  reg [2:0] abort_initiator_select = 0;
  wire trigger_in, frame_valid_in, acquire_active, continuous_capture, stream_active, frame_done;
  wire [15:0] frame_line_counter;
  wire [1:0] acquire_state;
  integer failures = 0, total_checks = 0, i;
  reg seen;
  sig_source src (.clk(clk), .trigger_in(trigger_in), .frame_valid_in(frame_valid_in));
  vertical_event_sequencer DUT
  (
    .clk                         (clk),
    .rst_b                       (rst_b),
    .trigger_in                  (trigger_in),
    .frame_valid_in              (frame_valid_in),
    .line_tick                   (line_tick),
    .vertical_acquire_window_end (vertical_acquire_window_end),
    .table_reset_event           (table_reset_event),
    .vertical_load_enable        (vertical_load_enable),
    .software_reset_event        (software_reset_event),
    .frame_quota_reached         (frame_quota_reached),
    .host_cmd_write              (host_cmd_write),
    .host_cmd                    (host_cmd),
    .zero_release_select         (zero_release_select),
    .counter_reset_select        (counter_reset_select),
    .stick_release_select        (stick_release_select),
    .counter_load_select         (counter_load_select),
    .acquire_initiator_select    (acquire_initiator_select),
    .freeze_initiator_select     (freeze_initiator_select),
    .abort_initiator_select      (abort_initiator_select),
    .frame_line_counter          (frame_line_counter),
    .acquire_active              (acquire_active),
    .continuous_capture          (continuous_capture),
    .stream_active               (stream_active),
    .acquire_state               (acquire_state),
    .frame_done                  (frame_done)
  );
  initial forever #20 clk = ~clk;
  task cyc(input integer n);
    repeat (n) begin @(posedge clk); #2; end
  endtask
  task check(input [15:0] got, exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cmd(input [1:0] c);
    begin
      host_cmd = c; host_cmd_write = 1; cyc(1); host_cmd_write = 0; cyc(1);
    end
  endtask
  task results;
    begin
      if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin #(40 * 40000); failures = failures + 1; results; end
  initial
  begin
    repeat (5) @(posedge clk);
    #2 rst_b = 1;
    check(frame_line_counter, `CNT_ZERO); check(acquire_state, `AS_IDLE);
    line_tick = 1; cyc(32760); check(frame_line_counter, `CNT_STICK);
    stick_release_select = 0; cyc(1); line_tick = 0; check(frame_line_counter, 16'h7FF1);
    counter_load_select = 2; src.frame(1); cyc(4); check(frame_line_counter, `CNT_LOAD);
    src.frame(0); counter_load_select = 0;
    software_reset_event = 1; cyc(1); software_reset_event = 0; check(frame_line_counter, 0);
    line_tick = 1; cyc(3); line_tick = 0; check(frame_line_counter, 3);
    table_reset_event = 1; cyc(1); table_reset_event = 0; check(frame_line_counter, 0);
    cyc(1); line_tick = 1; cyc(2); line_tick = 0; counter_reset_select = 0;
    vertical_acquire_window_end = 1; cyc(1); vertical_acquire_window_end = 0; check(frame_line_counter, 0);
    zero_release_select = 1; counter_reset_select = 5; line_tick = 1; cyc(5);
    check(frame_line_counter, 0);
    src.trig(1); cyc(6); line_tick = 0; check(frame_line_counter != 0, 1);
    src.trig(0); cyc(5); check(frame_line_counter, 0);
    counter_reset_select = 2; counter_load_select = 3; src.trig(1); cyc(5);
    check(frame_line_counter, `CNT_LOAD);
    src.trig(0); counter_load_select = 0; cmd(`CMD_ABORT); check(frame_line_counter, 0);
    cmd(`CMD_SINGLE); cyc(3); check(acquire_state, `AS_ARMED);
    src.frame(1); cyc(4); check(acquire_active, 1);
    src.frame(0); seen = 0;
    for (i = 0; i < 8; i = i + 1) begin cyc(1); seen = seen | frame_done; end
    check(seen, 1); check(acquire_state, `AS_IDLE);
    src.frame(1); cyc(4); check(acquire_active, 0); src.frame(0); cyc(4);
    cmd(`CMD_CONT); src.frame(1); cyc(4); cmd(`CMD_FREEZE); check(acquire_active, 1);
    src.frame(0); cyc(6); check(acquire_state, `AS_IDLE);
    cmd(`CMD_CONT); src.frame(1); cyc(4); cmd(`CMD_ABORT); check(acquire_active, 0);
    src.frame(0); acquire_initiator_select = 3; src.trig(1); cyc(7); check(stream_active, 1);
    src.trig(0); cyc(6); check(stream_active, 0);
    acquire_initiator_select = 0; counter_load_select = 1; src.frame(1); cyc(4);
    check(frame_line_counter, 0);
    src.frame(0); vertical_load_enable = 1; src.frame(1); cyc(4);
    check(frame_line_counter, `CNT_LOAD);
    src.frame(0); counter_load_select = 0; vertical_load_enable = 0; software_reset_event = 1; cyc(1);
    software_reset_event = 0; zero_release_select = 2; line_tick = 1; cyc(3);
    check(frame_line_counter, 0);
    src.trig(1); cyc(6); line_tick = 0;
    check(frame_line_counter != 0, 1);
    abort_initiator_select = 1; cmd(`CMD_CONT);
    check(continuous_capture, 1);
    src.trig(0); cyc(5);
    check(acquire_state, `AS_IDLE);
    check(continuous_capture, 0);
    abort_initiator_select = 0; freeze_initiator_select = 1; cmd(`CMD_CONT);
    frame_quota_reached = 1; cyc(1); frame_quota_reached = 0;
    check(acquire_state, `AS_IDLE);
    freeze_initiator_select = 2; cmd(`CMD_CONT); src.trig(1); cyc(4);
    check(acquire_state, `AS_ARMED);
    src.trig(0); cyc(5);
    check(acquire_state, `AS_IDLE);
    freeze_initiator_select = 0; acquire_initiator_select = 1; cmd(`CMD_SINGLE);
    check(acquire_state, `AS_IDLE);
    src.trig(1); cyc(4);
    check(acquire_state, `AS_ARMED);
    cmd(`CMD_ABORT); src.trig(0);
    results;
  end
endmodule // testbench
bind vertical_event_sequencer vseq_checker chk
(
  .clk                         (clk),
  .rst_b                       (rst_b),
  .trigger_in                  (trigger_in),
  .frame_valid_in              (frame_valid_in),
  .line_tick                   (line_tick),
  .vertical_acquire_window_end (vertical_acquire_window_end),
  .table_reset_event           (table_reset_event),
  .vertical_load_enable        (vertical_load_enable),
  .software_reset_event        (software_reset_event),
  .frame_quota_reached         (frame_quota_reached),
  .host_cmd_write              (host_cmd_write),
  .host_cmd                    (host_cmd),
  .zero_release_select         (zero_release_select),
  .counter_reset_select        (counter_reset_select),
  .stick_release_select        (stick_release_select),
  .counter_load_select         (counter_load_select),
  .acquire_initiator_select    (acquire_initiator_select),
  .freeze_initiator_select     (freeze_initiator_select),
  .abort_initiator_select      (abort_initiator_select),
  .frame_line_counter          (frame_line_counter),
  .acquire_active              (acquire_active),
  .continuous_capture          (continuous_capture),
  .stream_active               (stream_active),
  .frame_done                  (frame_done),
  .acquire_state               (acquire_state)
);

// File: tb/vseq_checker.sv
// Concurrent checks on the vertical event sequencer ports
`timescale 1ns/100ps
`include "vseq_defines.vh"
module vseq_checker
(
  // Clock, reset, pins and events
  input wire clk, rst_b, trigger_in, frame_valid_in, line_tick, vertical_acquire_window_end,
  input wire table_reset_event, vertical_load_enable, software_reset_event, frame_quota_reached,
  // Host command
  input wire host_cmd_write,
  input wire [`CMD_W-1:0] host_cmd,
  // Selectors
  input wire [`SEL_W-1:0] zero_release_select, counter_reset_select, stick_release_select,
  input wire [`SEL_W-1:0] counter_load_select, acquire_initiator_select, freeze_initiator_select,
  input wire [`SEL_W-1:0] abort_initiator_select,
  // Status
  input wire [`CNT_W-1:0] frame_line_counter,
  input wire acquire_active, continuous_capture, stream_active, frame_done,
  input wire [1:0] acquire_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // No competing reset or load source this cycle
  wire quiet = !software_reset_event && !host_cmd_write && !table_reset_event && !vertical_acquire_window_end
               && counter_reset_select == `RS_TABLE && counter_load_select == `LD_NONE;
  wire abort_wr = host_cmd_write && host_cmd == `CMD_ABORT;
  a_sw_reset_zero: assert property (software_reset_event |=> frame_line_counter == `CNT_ZERO)
    else $error("counter not cleared by software reset");
  a_abort_zero: assert property (abort_wr |=> frame_line_counter == `CNT_ZERO)
    else $error("counter not cleared by abort write");
  a_window_reset: assert property (vertical_acquire_window_end && counter_reset_select <= `RS_TFALL_VAW
    |=> frame_line_counter == `CNT_ZERO) else $error("counter not cleared at window end");
  a_table_reset: assert property (table_reset_event && (counter_reset_select == `RS_TABLE
    || counter_reset_select == `RS_TFALL_TABLE) |=> frame_line_counter == `CNT_ZERO) else $error("table reset lost");
  a_zero_pass: assert property (quiet && line_tick && zero_release_select == `ZR_NONE
    && frame_line_counter == `CNT_ZERO |=> frame_line_counter == 16'h0001) else $error("counter stopped at zero");
  a_stick_hold: assert property (stick_release_select == `ST_HOLD && frame_line_counter == `CNT_STICK
    && line_tick |=> frame_line_counter inside {`CNT_STICK, `CNT_ZERO, `CNT_LOAD}) else $error("stick point passed");
  a_frame_load: assert property ($rose(frame_valid_in) && counter_load_select == `LD_FRAME
    && counter_reset_select == `RS_TABLE |-> ##[1:4] frame_line_counter == `CNT_LOAD) else $error("load missed");
  a_stream_level: assert property ((acquire_initiator_select == `AQ_CONT && trigger_in)[*6]
    |-> stream_active) else $error("stream not active with trigger high");
  a_abort_idle: assert property (abort_wr |=> acquire_state == `AS_IDLE && !acquire_active)
    else $error("abort did not end capture");
  a_freeze_frame: assert property (host_cmd_write && host_cmd == `CMD_FREEZE && acquire_state == `AS_FRAME
    && freeze_initiator_select == `FZ_HOST |=> !continuous_capture) else $error("freeze not taken in frame");
endmodule // vseq_checker
